// ### design/lms_pred_pkg.sv
// Constants for the adaptive linear prediction filter
// Summary of operation
// RULE_01: Each input sample is the desired signal
// RULE_02: Filter input is stream delayed by delta
// RULE_03: Output is sum of coefficient times delayed sample
// RULE_04: Error equals desired minus filter output
// RULE_05: Coefficients add mu times error times sample
// RULE_06: Error stream is the cleaned output
// RULE_07: Taps, delay, step, widths are compile-time parameters
package lms_pred_pkg;
    localparam int DEF_TAPS     = 8;    // Filter length
    localparam int DEF_DELTA    = 2;    // Prediction delay in samples
    localparam int DEF_DATA_W   = 16;   // Signed sample width, Q1.(W-1)
    localparam int DEF_COEF_W   = 16;   // Signed coefficient width, Q1.(W-1)
    localparam int DEF_MU_SHIFT = 6;    // Step size mu = 2**-MU_SHIFT
    localparam int GUARD_W      = 8;    // Accumulator headroom bits
    localparam int COEF_RESET   = 0;    // Coefficient value after reset
    localparam int SAMPLE_RESET = 0;    // Delay line contents after reset
endpackage

// ### design/lms_prediction_filter.sv
// Adaptive LMS linear prediction filter removing narrowband interference
`timescale 1ns/10ps
module lms_prediction_filter
    import lms_pred_pkg::*;
#(
    parameter int TAPS     = DEF_TAPS,      // RULE_07
    parameter int DELTA    = DEF_DELTA,
    parameter int DATA_W   = DEF_DATA_W,
    parameter int COEF_W   = DEF_COEF_W,
    parameter int MU_SHIFT = DEF_MU_SHIFT
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    input  wire logic                     in_valid_i,
    output logic                          in_ready_o,
    input  wire logic [DATA_W-1:0]        in_data_i,
    input  wire logic                     adapt_en_i,
    output logic                          out_valid_o,
    output logic      [DATA_W-1:0]        out_data_o,
    output logic      [DATA_W-1:0]        est_data_o
);
    localparam int ACC_W = DATA_W + COEF_W + GUARD_W;

    typedef enum logic [1:0] {
        st_idle,
        st_filter,
        st_update
    } lms_state_e;

    // Sequencing state and datapath values
    lms_state_e                 state;
    lms_state_e                 next_state;
    logic                       take;
    logic signed [DATA_W-1:0]   desired;
    logic signed [DATA_W-1:0]   err;
    logic signed [DATA_W-1:0]   est;
    logic        [TAPS*DATA_W-1:0] tap_bus;
    logic signed [DATA_W-1:0]   tap  [TAPS];
    logic signed [COEF_W-1:0]   coef [TAPS];
    logic signed [ACC_W-1:0]    acc;
    logic signed [ACC_W-1:0]    y_wide;
    logic signed [ACC_W-1:0]    e_wide;
    logic signed [ACC_W-1:0]    y_sat;
    logic signed [ACC_W-1:0]    e_sat;
    logic signed [ACC_W-1:0]    prod [TAPS];
    logic signed [ACC_W-1:0]    step [TAPS];
    logic signed [ACC_W-1:0]    sum  [TAPS];
    logic                       upd_en;

    // Largest value of a w-bit signed range
    function automatic logic signed [ACC_W-1:0] sat_hi(input int w);
        sat_hi = ~({ACC_W{1'b1}} << (w - 1));
    endfunction

    // Smallest value of a w-bit signed range
    function automatic logic signed [ACC_W-1:0] sat_lo(input int w);
        sat_lo = ~sat_hi(w);
    endfunction

    // State decodes shared by handshake, datapath and update
    function automatic logic is_idle(input lms_state_e s);
        is_idle = (s == st_idle);
    endfunction

    function automatic logic is_filter(input lms_state_e s);
        is_filter = (s == st_filter);
    endfunction

    function automatic logic is_update(input lms_state_e s);
        is_update = (s == st_update);
    endfunction

    // Clamp a wide signed value to a signed range of w bits
    function automatic logic signed [ACC_W-1:0] clamp(input logic signed [ACC_W-1:0] v, input int w);
        logic signed [ACC_W-1:0] hi;
        logic signed [ACC_W-1:0] lo;
        hi = sat_hi(w);
        lo = sat_lo(w);
        if (v > hi) begin
            clamp = hi;
        end else if (v < lo) begin
            clamp = lo;
        end else begin
            clamp = v;
        end
    endfunction

    // Delay line fed by every accepted sample
    sample_delay_line #(
        .DATA_W (DATA_W),
        .DELTA  (DELTA),
        .TAPS   (TAPS)
    ) u_delay (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .shift_en_i (take),
        .sample_i   (in_data_i),
        .taps_o     (tap_bus)
    );

    // Signed view of each tap
    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_unpack
            assign tap[k] = $signed(tap_bus[k*DATA_W +: DATA_W]);
        end
    endgenerate

    // Per-tap product, widened before summing
    generate
        for (k = 0; k < TAPS; k++) begin : g_prod
            assign prod[k] = ACC_W'(tap[k] * coef[k]); // RULE_03
        end
    endgenerate

    // One sample accepted while idle
    assign take       = in_valid_i && is_idle(state);
    assign in_ready_o = is_idle(state);

    // Coefficients move only in the update cycle while adapting
    assign upd_en = is_update(state) && adapt_en_i;

    // Sequencer: accept, filter, update and emit
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                if (in_valid_i) begin
                    next_state = st_filter;
                end
            end
            st_filter: begin
                next_state = st_update;
            end
            st_update: begin
                next_state = st_idle;
            end
            default: begin
                next_state = st_idle; // Unused code recovers to idle
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Incoming sample is kept as desired signal
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            desired <= '0;
        end else if (take) begin
            desired <= $signed(in_data_i); // RULE_01
        end
    end

    // Sum of coefficient times delayed sample
    always_comb begin
        acc = '0;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + prod[i]; // RULE_03
        end
    end

    // Samples and coefficients are Q1.15, products Q2.30
    // Guard bits keep the sum from wrapping before the clamp
    // Estimate and error saturate back to sample width
    // Scale back to sample format, then form the error
    assign y_wide = acc >>> (COEF_W - 1);
    assign y_sat  = clamp(y_wide, DATA_W);
    assign e_wide = ACC_W'(desired) - y_sat; // RULE_04
    assign e_sat  = clamp(e_wide, DATA_W);

    // Error registered in the filter cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            err <= '0;
        end else if (is_filter(state)) begin
            err <= e_sat[DATA_W-1:0]; // RULE_04
        end
    end

    // Estimate registered alongside the error
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            est <= '0;
        end else if (is_filter(state)) begin
            est <= y_sat[DATA_W-1:0]; // RULE_03
        end
    end

    // Correction term mu * e * x(n-delta-k), saturated sum per tap
    generate
        for (k = 0; k < TAPS; k++) begin : g_step
            assign step[k] = ACC_W'((err * tap[k]) >>> (DATA_W - 1 + MU_SHIFT));
            assign sum[k]  = clamp(ACC_W'(coef[k]) + step[k], COEF_W);
        end
    endgenerate

    // Coefficient registers, same tap vector as the error used
    generate
        for (k = 0; k < TAPS; k++) begin : g_coef
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    coef[k] <= COEF_W'(COEF_RESET);
                end else if (upd_en) begin
                    coef[k] <= sum[k][COEF_W-1:0]; // RULE_05
                end
            end
        end
    endgenerate

    // Cleaned output is the error, one pulse per sample
    assign out_valid_o = is_update(state);     // RULE_06
    assign out_data_o  = err;                  // RULE_06

    // Narrowband estimate for observation
    assign est_data_o  = est;                  // RULE_03
endmodule

// ### design/sample_delay_line.sv
// Shift register giving the delayed tap vector x(n-delta-k)
`timescale 1ns/10ps
module sample_delay_line
    import lms_pred_pkg::*;
#(
    parameter int DATA_W = DEF_DATA_W,
    parameter int DELTA  = DEF_DELTA,
    parameter int TAPS   = DEF_TAPS
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    input  wire logic                     shift_en_i,
    input  wire logic [DATA_W-1:0]        sample_i,
    output logic      [TAPS*DATA_W-1:0]   taps_o
);
    localparam int DEPTH = DELTA + TAPS;

    logic [DATA_W-1:0] hist [DEPTH];

    // Newest sample enters slot 0, older ones move up
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                hist[i] <= DATA_W'(SAMPLE_RESET);
            end
        end else if (shift_en_i) begin
            hist[0] <= sample_i;
            for (int i = 1; i < DEPTH; i++) begin
                hist[i] <= hist[i-1];
            end
        end
    end

    // Tap k reads slot delta+k, i.e. x(n-delta-k)
    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_tap
            assign taps_o[k*DATA_W +: DATA_W] = hist[DELTA+k]; // RULE_02
        end
    endgenerate
endmodule

// ### verification/lms_filt_chk.sv
// Port checks for the prediction filter
`timescale 1ns/10ps
module lms_filt_chk
    import lms_pred_pkg::*;
#(parameter int DATA_W = DEF_DATA_W) (
    input wire logic              mclk_i,
    input wire logic              rst_i,
    input wire logic              in_valid_i,
    input wire logic              in_ready_o,
    input wire logic [DATA_W-1:0] in_data_i,
    input wire logic              out_valid_o,
    input wire logic [DATA_W-1:0] out_data_o,
    input wire logic [DATA_W-1:0] est_data_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Handshake, latency, pairing and hold
    take_lat_a: assert property (in_valid_i && in_ready_o |=>
        !in_ready_o ##1 (out_valid_o && !in_ready_o) ##1 in_ready_o) else $error("bad latency");
    one_pulse_a: assert property (out_valid_o |=> !out_valid_o) else $error("long pulse");
    out_cause_a: assert property (out_valid_o |-> $past(in_valid_i && in_ready_o, 2)) else $error("stray");
    out_hold_a: assert property ($changed(out_data_o) |-> out_valid_o) else $error("out moved");
    est_hold_a: assert property ($changed(est_data_o) |-> out_valid_o) else $error("est moved");
    busy_why_a: assert property (!in_ready_o |-> $past(in_valid_i && in_ready_o) ||
        $past(in_valid_i && in_ready_o, 2)) else $error("busy");
    // Error equals desired minus estimate when no saturation
    err_sum_a: assert property (out_valid_o && ^est_data_o[DATA_W-1-:2] == 0 &&
        ^$past(in_data_i[DATA_W-1-:2], 2) == 0 |-> out_data_o + est_data_o == $past(in_data_i, 2))
        else $error("bad error");
endmodule

bind lms_prediction_filter lms_filt_chk #(.DATA_W(DATA_W)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_data_i(in_data_i), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .est_data_o(est_data_o));

// ### verification/lms_stream_model.sv
// Sample source and sink for the filter stream
`timescale 1ns/10ps
module lms_stream_model
    import lms_pred_pkg::*;
(
    input  wire logic                  mclk_i,
    input  wire logic                  in_ready_i,
    input  wire logic                  out_valid_i,
    input  wire logic [DEF_DATA_W-1:0] out_data_i,
    input  wire logic [DEF_DATA_W-1:0] est_data_i,
    output logic                       in_valid_o,
    output logic      [DEF_DATA_W-1:0] in_data_o
);
    // Idle source at time zero
    initial begin
        in_valid_o = 1'b0;
        in_data_o = 16'h0000;
    end
    // Offer one sample, then take its result and estimate
    task automatic xfer(input logic [DEF_DATA_W-1:0] d, output logic [DEF_DATA_W-1:0] e, y);
        int n;
        in_valid_o <= 1'b1;
        in_data_o <= d;
        do @(posedge mclk_i); while (!in_ready_i);
        in_valid_o <= 1'b0;
        in_data_o <= ~d; // Released data does not hold
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (!out_valid_i && n < 8);
        e = out_valid_i ? out_data_i : 'x;
        y = est_data_i;
    endtask
endmodule

// ### verification/test_lms_prediction_filter.sv
// Self-checking bench for the prediction filter
`timescale 1ns/10ps
module test_lms_prediction_filter
    import lms_pred_pkg::*;
;
    logic                  mclk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  adapt_en_i = 1'b0;
    logic                  in_valid_i, in_ready_o, out_valid_o;
    logic [DEF_DATA_W-1:0] in_data_i, out_data_o, est_data_o, e, y;
    int                    failures = 0;
    int                    compares = 0;
    always #20 mclk_i = ~mclk_i;
    // Filter and its stream partner
    lms_prediction_filter u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
        .in_data_i(in_data_i), .adapt_en_i(adapt_en_i), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
        .est_data_o(est_data_o));
    lms_stream_model u_src (.mclk_i(mclk_i), .in_ready_i(in_ready_o), .out_valid_i(out_valid_o),
        .out_data_i(out_data_o), .est_data_i(est_data_o), .in_valid_o(in_valid_i), .in_data_o(in_data_i));
    task automatic chk(input string name, input logic [DEF_DATA_W-1:0] exp, got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic reset_dut();
        rst_i <= 1'b1;
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        chk("rst out", 16'h0000, out_data_o);
    endtask
    // Zero coefficients pass the sample straight through
    task automatic zero_coef_pass();
        reset_dut();
        u_src.xfer(16'h1234, e, y);
        chk("out", 16'h1234, e);
        chk("est", 16'h0000, y);
        u_src.xfer(16'hEDCB, e, y);
        chk("out", 16'hEDCB, e);
    endtask
    // Adapt on a constant, then freeze
    task automatic adapt_and_freeze();
        reset_dut();
        adapt_en_i <= 1'b1;
        repeat (3) begin
            u_src.xfer(16'h4000, e, y);
            chk("est", 16'h0000, y);
        end
        adapt_en_i <= 1'b0;
        u_src.xfer(16'h4000, e, y);
        chk("out", 16'h3FC0, e);
        u_src.xfer(16'h4000, e, y);
        chk("est", 16'h0040, y);
    endtask
    initial begin
        zero_coef_pass();
        adapt_and_freeze();
        final_report();
    end
    // Watchdog far beyond the run length
    initial begin
        #100us;
        failures++;
        final_report();
    end
endmodule
